// file: rtl/fesc_ctrl.sv
// Erase, erase-status, erase-count and suspend/resume controller of a serial flash
`timescale 1ns/10ps
module fesc_ctrl
  import fesc_pkg::*;
#(
  parameter int PPB_W = 32,
  parameter int OP_CYC = 50,
  parameter int NSECT = 16
)(
  // Clock, reset, enable
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  // Register port
  input wire logic [3:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  // Status outputs
  output logic busy_flag_out,
  output logic array_read_undef_out
);

  // Parameter sanity, refused at elaboration; sector select must cover the array exactly
  if (PPB_W < 1 || PPB_W > 32 || NSECT < 2 || NSECT > 256 || OP_CYC < 1 || OP_CYC > 65535 ||
      (2 ** $clog2(NSECT)) != NSECT)
  begin : g_bad_params
    $error("fesc_ctrl: unsupported parameters");
  end

  localparam int SW = $clog2(NSECT);
  localparam int TW = 16;
  localparam logic [TW-1:0] T_EVAL = TW'(EVAL_CYC);
  localparam logic [TW-1:0] T_COUNT = TW'(COUNT_CYC);
  localparam logic [TW-1:0] T_SUSP = TW'(SUSPEND_CYC);
  localparam logic [TW-1:0] T_OP = TW'(OP_CYC);

  fesc_req_t req;
  assign req = '{wr: reg_wr_in, rd: reg_rd_in, addr: reg_addr_in, wdata: reg_wdata_in};

  fesc_state_t state_ff;
  fesc_op_t op_ff, outer_op_ff;
  logic [TW-1:0] tmr_ff, outer_tmr_ff;
  logic wel_ff, ok_ff;
  logic [7:0] str2_ff;
  logic [31:0] count_ff;
  logic [3:0] prot_opt_ff;
  logic latch_ff;
  logic [PPB_W-1:0] ppb_ff;
  logic [SW-1:0] sect_ff;
  logic [NSECT-1:0] erased_ok_ff;
  logic [CNT_W:0] sect_cnt_mem [NSECT];
  logic nested_ff;

  // Decoded command write
  logic cmd_wr;
  fesc_cmd_t cmd;
  logic suspended, ppb_locked, busy;
  assign cmd_wr = clk_en_in && req.wr && req.addr == ADDR_CMD;
  assign cmd = fesc_cmd_t'(req.wdata[3:0]);
  assign suspended = str2_ff[PROG_SUSP_BIT] | str2_ff[ERASE_SUSP_BIT] | str2_ff[CHECK_SUSP_BIT];
  assign ppb_locked = prot_opt_ff[PPB_OPT_BIT] | prot_opt_ff[PERM_OPT_BIT] | latch_ff;
  assign busy = state_ff == FESC_ST_RUN || state_ff == FESC_ST_STOP;

  // Operation start conditions
  logic start_ok;
  always_comb
  begin
    start_ok = 1'b0;
    if (cmd_wr && (state_ff == FESC_ST_IDLE || (state_ff == FESC_ST_SUSP && !nested_ff)))
    begin
      unique case (cmd)
        FESC_CMD_EVAL, FESC_CMD_COUNT: start_ok = !suspended;
        FESC_CMD_PROGRAM: start_ok = wel_ff && (!suspended || str2_ff[ERASE_SUSP_BIT]);
        FESC_CMD_SECT_ERASE, FESC_CMD_CHIP_ERASE: start_ok = wel_ff && !suspended;
        FESC_CMD_CHECK: start_ok = !suspended;
        FESC_CMD_PPB_ERASE: start_ok = wel_ff && !suspended && !ppb_locked;
        default: start_ok = 1'b0;
      endcase
    end
  end

  logic [2:0] start_op;
  always_comb
  begin
    unique case (cmd)
      FESC_CMD_EVAL: start_op = FESC_OP_EVAL;
      FESC_CMD_COUNT: start_op = FESC_OP_COUNT;
      FESC_CMD_PROGRAM: start_op = FESC_OP_PROG;
      FESC_CMD_SECT_ERASE: start_op = FESC_OP_SERASE;
      FESC_CMD_CHIP_ERASE: start_op = FESC_OP_CERASE;
      FESC_CMD_CHECK: start_op = FESC_OP_CHECK;
      default: start_op = FESC_OP_PPB;
    endcase
  end

  // Suspend honoured only for program, sector erase and check
  logic susp_ok;
  assign susp_ok = cmd_wr && cmd == FESC_CMD_SUSPEND && state_ff == FESC_ST_RUN && !nested_ff &&
                   (op_ff == FESC_OP_PROG || op_ff == FESC_OP_SERASE || op_ff == FESC_OP_CHECK);
  logic resume_ok;
  assign resume_ok = cmd_wr && cmd == FESC_CMD_RESUME && state_ff == FESC_ST_SUSP && !nested_ff;
  logic done;
  assign done = clk_en_in && (state_ff == FESC_ST_RUN || state_ff == FESC_ST_STOP) && tmr_ff == '0;

  // Sequencer state, operation and timer
  always_ff @(posedge mclk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      state_ff <= FESC_ST_IDLE;
      op_ff <= FESC_OP_NONE;
      outer_op_ff <= FESC_OP_NONE;
      tmr_ff <= '0;
      outer_tmr_ff <= '0;
      nested_ff <= 1'b0;
    end
    else if (clk_en_in)
    begin
      if (start_ok)
      begin
        if (state_ff == FESC_ST_SUSP)
        begin
          // Program inside erase suspend keeps the erase parked
          nested_ff <= 1'b1;
          outer_op_ff <= op_ff;
          outer_tmr_ff <= outer_tmr_ff;
        end
        state_ff <= FESC_ST_RUN;
        op_ff <= fesc_op_t'(start_op);
        tmr_ff <= (start_op == FESC_OP_EVAL) ? T_EVAL - 1'b1 :
                  (start_op == FESC_OP_COUNT) ? T_COUNT - 1'b1 : T_OP - 1'b1;
      end
      else if (susp_ok)
      begin
        state_ff <= FESC_ST_STOP;
        outer_tmr_ff <= tmr_ff;
        tmr_ff <= T_SUSP - 1'b1;
      end
      else if (resume_ok)
      begin
        state_ff <= FESC_ST_RUN;
        tmr_ff <= outer_tmr_ff;
      end
      else if (done)
      begin
        if (state_ff == FESC_ST_STOP)
          state_ff <= FESC_ST_SUSP;
        else if (nested_ff)
        begin
          state_ff <= FESC_ST_SUSP;
          op_ff <= outer_op_ff;
          nested_ff <= 1'b0;
        end
        else
        begin
          state_ff <= FESC_ST_IDLE;
          op_ff <= FESC_OP_NONE;
        end
      end
      else if (tmr_ff != '0 && busy)
        tmr_ff <= tmr_ff - 1'b1;
    end
  end

  // Write enable latch, cleared when a guarded operation starts
  always_ff @(posedge mclk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      wel_ff <= 1'b0;
    else if (clk_en_in)
    begin
      if (cmd_wr && cmd == FESC_CMD_WREN && (!suspended || str2_ff[ERASE_SUSP_BIT]))
        wel_ff <= 1'b1;
      else if (start_ok && start_op != FESC_OP_EVAL && start_op != FESC_OP_COUNT && start_op != FESC_OP_CHECK)
        wel_ff <= 1'b0;
    end
  end

  // Suspend flags and erase status; set on the edge busy falls, suspend flags cleared on resume
  always_ff @(posedge mclk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      str2_ff <= STAT_RST;
    else if (clk_en_in)
    begin
      if (done && state_ff == FESC_ST_STOP)
      begin
        str2_ff[PROG_SUSP_BIT] <= op_ff == FESC_OP_PROG;
        str2_ff[ERASE_SUSP_BIT] <= op_ff == FESC_OP_SERASE;
        str2_ff[CHECK_SUSP_BIT] <= op_ff == FESC_OP_CHECK;
      end
      else if (resume_ok)
      begin
        str2_ff[PROG_SUSP_BIT] <= 1'b0;
        str2_ff[ERASE_SUSP_BIT] <= 1'b0;
        str2_ff[CHECK_SUSP_BIT] <= 1'b0;
      end
      if (done && state_ff == FESC_ST_RUN && op_ff == FESC_OP_EVAL)
        str2_ff[ERASE_OK_BIT] <= erased_ok_ff[sect_ff];
    end
  end

  // Per-sector erase outcome and counts
  always_ff @(posedge mclk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      erased_ok_ff <= '0;
      for (int i = 0; i < NSECT; i++)
        sect_cnt_mem[i] <= '0;
    end
    else if (clk_en_in)
    begin
      if (req.wr && req.addr == ADDR_SECT_DATA && !suspended && !busy)
      begin
        erased_ok_ff[sect_ff] <= req.wdata[31];
        sect_cnt_mem[sect_ff] <= req.wdata[CNT_W:0];
      end
      else if (done && state_ff == FESC_ST_RUN && !nested_ff && op_ff == FESC_OP_SERASE)
      begin
        erased_ok_ff[sect_ff] <= 1'b1;
        sect_cnt_mem[sect_ff] <= {1'b0, sect_cnt_mem[sect_ff][CNT_W-1:0] + 1'b1};
      end
      else if (start_ok && start_op == FESC_OP_SERASE)
        erased_ok_ff[sect_ff] <= 1'b0;
    end
  end

  // Count register loaded at end of the count operation
  always_ff @(posedge mclk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      count_ff <= COUNT_RST;
    else if (clk_en_in && done && state_ff == FESC_ST_RUN && op_ff == FESC_OP_COUNT)
      count_ff <= {8'h00, sect_cnt_mem[sect_ff]};
  end

  // Protection options, lock latch and sector select; blocked while suspended
  always_ff @(posedge mclk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      prot_opt_ff <= 4'h0;
      latch_ff <= 1'b0;
      sect_ff <= '0;
    end
    else if (clk_en_in && req.wr && !suspended)
    begin
      if (req.addr == ADDR_PROTECT)
        prot_opt_ff <= req.wdata[3:0];
      if (req.addr == ADDR_LOCK_LATCH)
        latch_ff <= req.wdata[LATCH_BIT];
      if (req.addr == ADDR_SECTOR && !busy)
        sect_ff <= req.wdata[SW-1:0];
    end
  end

  // Lock bits: register write clears bits, bit erase sets all
  always_ff @(posedge mclk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      ppb_ff <= '1;
    else if (clk_en_in)
    begin
      if (done && state_ff == FESC_ST_RUN && op_ff == FESC_OP_PPB)
        ppb_ff <= '1;
      else if (req.wr && req.addr == ADDR_PPB_LO && !suspended && !busy && !ppb_locked)
        ppb_ff <= ppb_ff & req.wdata[PPB_W-1:0];
    end
  end

  // Read data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge mclk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      reg_rdata_out <= '0;
    else if (clk_en_in)
    begin
      reg_rdata_out <= '0;
      if (req.rd)
      begin
        unique case (req.addr)
          ADDR_STATUS_ONE: reg_rdata_out <= {30'h0, wel_ff, busy};
          ADDR_STATUS_TWO: reg_rdata_out <= {24'h0, str2_ff};
          ADDR_COUNT: reg_rdata_out <= count_ff;
          ADDR_PROTECT: reg_rdata_out <= {28'h0, prot_opt_ff};
          ADDR_LOCK_LATCH: reg_rdata_out <= {31'h0, latch_ff};
          ADDR_SECTOR: reg_rdata_out <= 32'(sect_ff);
          ADDR_PPB_LO: reg_rdata_out <= 32'(ppb_ff);
          default: reg_rdata_out <= '0;
        endcase
      end
    end
  end

  // Busy and undefined-read outputs registered
  always_ff @(posedge mclk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      busy_flag_out <= 1'b0;
      array_read_undef_out <= 1'b0;
    end
    else if (clk_en_in)
    begin
      busy_flag_out <= busy;
      array_read_undef_out <= str2_ff[PROG_SUSP_BIT] | str2_ff[ERASE_SUSP_BIT];
    end
  end

  // Assertions
  property p_ppb_set;
    @(posedge mclk_in) disable iff (sys_rst_in)
    (clk_en_in && done && state_ff == FESC_ST_RUN && op_ff == FESC_OP_PPB) |=> ppb_ff == '1;
  endproperty
  a_ppb_set: assert property (p_ppb_set) else $error("lock bits not set");

  property p_ppb_abort;
    @(posedge mclk_in) disable iff (sys_rst_in)
    (cmd_wr && cmd == FESC_CMD_PPB_ERASE && ppb_locked && !busy) |=> !busy && ppb_ff == $past(ppb_ff);
  endproperty
  a_ppb_abort: assert property (p_ppb_abort) else $error("locked bit erase started");

  property p_eval_res;
    @(posedge mclk_in) disable iff (sys_rst_in)
    (done && state_ff == FESC_ST_RUN && op_ff == FESC_OP_EVAL) |=> str2_ff[ERASE_OK_BIT] == $past(erased_ok_ff[sect_ff]);
  endproperty
  a_eval_res: assert property (p_eval_res) else $error("erase status wrong");

  sequence s_eval_start;
    clk_en_in && start_ok && start_op == FESC_OP_EVAL && state_ff == FESC_ST_IDLE;
  endsequence
  property p_eval_busy;
    @(posedge mclk_in) disable iff (sys_rst_in)
    s_eval_start |=> busy [*8];
  endproperty
  a_eval_busy: assert property (p_eval_busy) else $error("busy dropped early");

  property p_count_load;
    @(posedge mclk_in) disable iff (sys_rst_in)
    (done && state_ff == FESC_ST_RUN && op_ff == FESC_OP_COUNT) |=> count_ff[CNT_W:0] == $past(sect_cnt_mem[sect_ff]) && !busy;
  endproperty
  a_count_load: assert property (p_count_load) else $error("count not loaded");

  property p_susp_stop;
    @(posedge mclk_in) disable iff (sys_rst_in)
    (susp_ok && !start_ok) |=> state_ff == FESC_ST_STOP && tmr_ff == T_SUSP - 1'b1;
  endproperty
  a_susp_stop: assert property (p_susp_stop) else $error("suspend not started");

  property p_erase_ignored;
    @(posedge mclk_in) disable iff (sys_rst_in)
    (cmd_wr && state_ff == FESC_ST_SUSP && (cmd == FESC_CMD_SECT_ERASE || cmd == FESC_CMD_CHIP_ERASE)) |=>
      state_ff == FESC_ST_SUSP;
  endproperty
  a_erase_ignored: assert property (p_erase_ignored) else $error("erase while suspended");

  property p_chip_nosusp;
    @(posedge mclk_in) disable iff (sys_rst_in)
    (op_ff == FESC_OP_CERASE) |-> state_ff != FESC_ST_STOP && state_ff != FESC_ST_SUSP;
  endproperty
  a_chip_nosusp: assert property (p_chip_nosusp) else $error("chip erase suspended");

  property p_resume_clr;
    @(posedge mclk_in) disable iff (sys_rst_in)
    resume_ok |=> !suspended && busy;
  endproperty
  a_resume_clr: assert property (p_resume_clr) else $error("resume flags wrong");

endmodule

// file: rtl/fesc_pkg.sv
// Shared constants, types and timing for the erase, status and suspend controller
package fesc_pkg;
  // Clock rate and derived cycle counts
  localparam int CLK_HZ = 10_000_000;
  localparam int CLK_NS = 1_000_000_000 / CLK_HZ;
  // Evaluation, count and suspend times in microseconds
  localparam int EVAL_TIME_US = 20;
  localparam int COUNT_TIME_US = 20;
  localparam int SUSPEND_TIME_US = 40;
  localparam int EVAL_CYC = (EVAL_TIME_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int COUNT_CYC = (COUNT_TIME_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int SUSPEND_CYC = (SUSPEND_TIME_US * 1000) / CLK_NS;
  // Register offsets on the plain register port
  localparam logic [3:0] ADDR_CMD = 4'h0;
  localparam logic [3:0] ADDR_STATUS_ONE = 4'h1;
  localparam logic [3:0] ADDR_STATUS_TWO = 4'h2;
  localparam logic [3:0] ADDR_COUNT = 4'h3;
  localparam logic [3:0] ADDR_PROTECT = 4'h4;
  localparam logic [3:0] ADDR_LOCK_LATCH = 4'h5;
  localparam logic [3:0] ADDR_SECTOR = 4'h6;
  localparam logic [3:0] ADDR_PPB_LO = 4'h7;
  localparam logic [3:0] ADDR_SECT_DATA = 4'h8;
  // Field positions
  localparam int BUSY_BIT = 0;
  localparam int WEL_BIT = 1;
  localparam int PROG_SUSP_BIT = 0;
  localparam int ERASE_SUSP_BIT = 1;
  localparam int ERASE_OK_BIT = 2;
  localparam int CHECK_SUSP_BIT = 4;
  localparam int PPB_OPT_BIT = 3;
  localparam int PERM_OPT_BIT = 0;
  localparam int LATCH_BIT = 0;
  localparam int CNT_CORRUPT_BIT = 23;
  localparam int CNT_W = 23;
  // Reset values
  localparam logic [31:0] COUNT_RST = 32'h0000_0000;
  localparam logic [7:0] STAT_RST = 8'h00;
  // Commands written to the command register
  typedef enum logic [3:0] {
    FESC_CMD_WREN = 4'h1,
    FESC_CMD_PPB_ERASE = 4'h2,
    FESC_CMD_EVAL = 4'h3,
    FESC_CMD_COUNT = 4'h4,
    FESC_CMD_SUSPEND = 4'h5,
    FESC_CMD_RESUME = 4'h6,
    FESC_CMD_PROGRAM = 4'h7,
    FESC_CMD_SECT_ERASE = 4'h8,
    FESC_CMD_CHIP_ERASE = 4'h9,
    FESC_CMD_CHECK = 4'ha,
    FESC_CMD_WR_REG = 4'hb
  } fesc_cmd_t;
  // Embedded operation kinds
  typedef enum logic [2:0] {
    FESC_OP_NONE = 3'h0,
    FESC_OP_PROG = 3'h1,
    FESC_OP_SERASE = 3'h2,
    FESC_OP_CERASE = 3'h3,
    FESC_OP_CHECK = 3'h4,
    FESC_OP_EVAL = 3'h5,
    FESC_OP_COUNT = 3'h6,
    FESC_OP_PPB = 3'h7
  } fesc_op_t;
  // Sequencer states, Gray along idle-run-stopping-suspended
  typedef enum logic [1:0] {
    FESC_ST_IDLE = 2'b00,
    FESC_ST_RUN = 2'b01,
    FESC_ST_STOP = 2'b11,
    FESC_ST_SUSP = 2'b10
  } fesc_state_t;
  // Register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [31:0] wdata;
  } fesc_req_t;
endpackage

// file: sim/fesc_host_model.sv
// Host-side model that issues register-port transactions to the controller
`timescale 1ns/10ps
module fesc_host_model
  import fesc_pkg::*;
(
  // Clock and returned data
  input wire logic mclk_in,
  input wire logic [31:0] rdata_in,
  // Request lines
  output logic [3:0] addr_out,
  output logic [31:0] wdata_out,
  output logic wr_out,
  output logic rd_out
);
  // Quiet bus at time zero
  initial
  begin
    addr_out = 4'h0;
    wdata_out = 32'h0;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end

  // Released strobes drop and address and data are inverted so a stale value never looks valid
  task automatic release_bus();
    wr_out <= 1'b0;
    rd_out <= 1'b0;
    addr_out <= ~addr_out;
    wdata_out <= ~wdata_out;
  endtask

  // One-cycle write strobe
  task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    addr_out <= a;
    wdata_out <= d;
    wr_out <= 1'b1;
    @(posedge mclk_in);
    release_bus();
  endtask

  // One-cycle read strobe, data taken in the following cycle only
  task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge mclk_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge mclk_in);
    release_bus();
    @(posedge mclk_in);
    d = rdata_in;
  endtask

  // Command register write
  task automatic cmd(input logic [3:0] c);
    bus_wr(ADDR_CMD, {28'h0, c});
  endtask

  // Busy is polled to learn when an operation has stopped
  task automatic poll_idle(output logic ok);
    logic [31:0] s;
    ok = 1'b0;
    for (int i = 0; i < 3000 && ok == 1'b0; i++)
    begin
      bus_rd(ADDR_STATUS_ONE, s);
      ok = (s[BUSY_BIT] === 1'b0);
    end
  endtask

  // Suspended work continues only after an explicit resume
  task automatic resume();
    cmd(FESC_CMD_RESUME);
  endtask

  // A sector reported not erased is erased again before use
  task automatic reerase(input logic [31:0] sect);
    bus_wr(ADDR_SECTOR, sect);
    cmd(FESC_CMD_WREN);
    cmd(FESC_CMD_SECT_ERASE);
  endtask
endmodule

// file: sim/tb_top.sv
// Self-checking bench for the erase, status and suspend controller
`timescale 1ns/10ps
module tb_top
  import fesc_pkg::*;
;
  logic mclk_in;
  logic sys_rst_in;
  logic clk_en_in;
  logic [3:0] reg_addr_in;
  logic [31:0] reg_wdata_in;
  logic reg_wr_in;
  logic reg_rd_in;
  logic [31:0] reg_rdata_out;
  logic busy_flag_out;
  logic array_read_undef_out;
  int bad_count;
  int checks;
  int cyc;
  logic ok;
  logic [3:0] la [4] = '{ADDR_LOCK_LATCH, ADDR_PROTECT, ADDR_PROTECT, ADDR_SECTOR};
  logic [31:0] lv [4] = '{32'h1, 32'h8, 32'h1, 32'h0};
  logic [31:0] ed [2] = '{32'h8000_0000, 32'h0000_0000};
  logic [31:0] cd [2] = '{32'h0080_1234, 32'h007f_ffff};

  fesc_ctrl #(.OP_CYC(5)) uut (
    .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .clk_en_in(clk_en_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .busy_flag_out(busy_flag_out),
    .array_read_undef_out(array_read_undef_out)
  );

  fesc_host_model partner (
    .mclk_in(mclk_in), .rdata_in(reg_rdata_out), .addr_out(reg_addr_in),
    .wdata_out(reg_wdata_in), .wr_out(reg_wr_in), .rd_out(reg_rd_in)
  );

  // 10 MHz clock
  initial
  begin
    mclk_in = 1'b0;
    sys_rst_in = 1'b1;
    clk_en_in = 1'b1;
  end
  always #50 mclk_in = ~mclk_in;

  // Cycle ceiling well above the expected run length
  always @(posedge mclk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      bad_count++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    if (bad_count == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Reset held for three cycles
  task automatic do_reset();
    @(posedge mclk_in);
    sys_rst_in <= 1'b1;
    repeat (3) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp, input logic [31:0] m = 32'hffff_ffff);
    logic [31:0] v;
    partner.bus_rd(a, v);
    check(v & m, exp);
  endtask

  task automatic idle_chk();
    partner.poll_idle(ok);
    check({31'h0, ok}, 32'h1);
  endtask

  // Registered busy shows one edge after the taking edge and is checked at the second
  task automatic busy_chk();
    repeat (2) @(posedge mclk_in);
    #1;
    check({31'h0, busy_flag_out}, 32'h1);
  endtask

  // Issue a command and measure how long busy stays up
  task automatic timed(input logic [3:0] c, input int lo, input int hi);
    int n;
    n = 0;
    partner.cmd(c);
    busy_chk();
    while (busy_flag_out !== 1'b0 && n < 3000)
    begin
      @(posedge mclk_in);
      #1;
      n++;
    end
    check({31'h0, n >= lo && n <= hi}, 32'h1);
  endtask

  task automatic resume_chk();
    partner.resume();
    busy_chk();
    idle_chk();
    rd_chk(ADDR_STATUS_TWO, 32'h0);
  endtask

  initial
  begin
    bad_count = 0;
    checks = 0;
    cyc = 0;
    repeat (3) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    // Reset values and an unmapped place
    rd_chk(ADDR_STATUS_ONE, 32'h0);
    rd_chk(ADDR_STATUS_TWO, 32'h0);
    rd_chk(ADDR_COUNT, COUNT_RST);
    partner.bus_wr(4'hf, 32'h0);
    rd_chk(4'hf, 32'h0);
    rd_chk(ADDR_PPB_LO, 32'hffff_ffff);
    // Lock-bit erase under each lock source, then unlocked
    for (int k = 0; k < 4; k++)
    begin
      do_reset();
      partner.bus_wr(ADDR_PPB_LO, 32'h0);
      partner.bus_wr(la[k], lv[k]);
      partner.cmd(FESC_CMD_WREN);
      rd_chk(ADDR_STATUS_ONE, 32'h2);
      partner.cmd(FESC_CMD_PPB_ERASE);
      idle_chk();
      rd_chk(ADDR_PPB_LO, (k == 3) ? 32'hffff_ffff : 32'h0);
    end
    // Erase-status evaluation without write enable, good and bad sector
    do_reset();
    for (int k = 0; k < 2; k++)
    begin
      partner.bus_wr(ADDR_SECTOR, 32'h3 + 32'(k));
      partner.bus_wr(ADDR_SECT_DATA, ed[k]);
      timed(FESC_CMD_EVAL, EVAL_CYC - 4, EVAL_CYC + 4);
      rd_chk(ADDR_STATUS_TWO, (k == 0) ? 32'h4 : 32'h0);
    end
    partner.reerase(32'h4);
    idle_chk();
    // Erase counts, corrupt flag and full 23-bit value
    for (int k = 0; k < 2; k++)
    begin
      partner.bus_wr(ADDR_SECTOR, 32'h8 + 32'(k));
      partner.bus_wr(ADDR_SECT_DATA, cd[k]);
      timed(FESC_CMD_COUNT, COUNT_CYC - 4, COUNT_CYC + 4);
      rd_chk(ADDR_COUNT, cd[k]);
    end
    // Writes while the clock enable is low are lost
    clk_en_in <= 1'b0;
    partner.bus_wr(ADDR_SECTOR, 32'h5);
    clk_en_in <= 1'b1;
    rd_chk(ADDR_SECTOR, 32'h9);
    // Suspend with nothing running is ignored
    partner.cmd(FESC_CMD_SUSPEND);
    rd_chk(ADDR_STATUS_ONE, 32'h0, 32'h1);
    rd_chk(ADDR_STATUS_TWO, 32'h0);
    // Program suspend, refused writes, resume
    partner.cmd(FESC_CMD_WREN);
    partner.cmd(FESC_CMD_PROGRAM);
    timed(FESC_CMD_SUSPEND, 1, SUSPEND_CYC + 2);
    rd_chk(ADDR_STATUS_TWO, 32'h1);
    check({31'h0, array_read_undef_out}, 32'h1);
    partner.bus_wr(ADDR_PPB_LO, 32'h0);
    rd_chk(ADDR_PPB_LO, 32'hffff_ffff);
    partner.cmd(FESC_CMD_WREN);
    partner.cmd(FESC_CMD_PPB_ERASE);
    rd_chk(ADDR_STATUS_ONE, 32'h0);
    resume_chk();
    check({31'h0, array_read_undef_out}, 32'h0);
    // Sector erase suspend, ignored erase, nested program
    partner.cmd(FESC_CMD_WREN);
    partner.cmd(FESC_CMD_SECT_ERASE);
    timed(FESC_CMD_SUSPEND, 1, SUSPEND_CYC + 2);
    rd_chk(ADDR_STATUS_TWO, 32'h2);
    check({31'h0, array_read_undef_out}, 32'h1);
    partner.cmd(FESC_CMD_WREN);
    partner.cmd(FESC_CMD_SECT_ERASE);
    rd_chk(ADDR_STATUS_ONE, 32'h2);
    partner.cmd(FESC_CMD_WREN);
    partner.cmd(FESC_CMD_PROGRAM);
    busy_chk();
    idle_chk();
    rd_chk(ADDR_STATUS_TWO, 32'h2);
    resume_chk();
    // Whole-chip erase cannot be suspended
    partner.cmd(FESC_CMD_WREN);
    partner.cmd(FESC_CMD_CHIP_ERASE);
    partner.cmd(FESC_CMD_SUSPEND);
    idle_chk();
    rd_chk(ADDR_STATUS_TWO, 32'h0);
    // Integrity-check suspend
    partner.cmd(FESC_CMD_CHECK);
    timed(FESC_CMD_SUSPEND, 1, SUSPEND_CYC + 2);
    rd_chk(ADDR_STATUS_TWO, 32'h10);
    partner.bus_wr(ADDR_PPB_LO, 32'h0);
    rd_chk(ADDR_PPB_LO, 32'hffff_ffff);
    partner.bus_wr(ADDR_PROTECT, 32'h8);
    rd_chk(ADDR_PROTECT, 32'h0);
    resume_chk();
    print_verdict();
  end
endmodule
